// ==== rtl/mpu_checker.sv ====
/*
  Memory protection checker: Avalon-MM register block, region tables for
  data and instruction accesses, fault detection and interrupt.
  Assumes access requests come from core logic on clk_sys_in and that
  software disables checking while it rewrites regions.
*/
`timescale 1ns/1ps
module mpu_checker
  import mpu_pkg::*;
#(
  parameter int unsigned DATA_REGIONS    = DEF_REGIONS,
  parameter int unsigned INSTR_REGIONS   = DEF_REGIONS,
  parameter int unsigned DATA_GRAN_LOG2  = DEF_GRAN_LOG2,
  parameter int unsigned INSTR_GRAN_LOG2 = DEF_GRAN_LOG2,
  parameter bit          USE_LIMIT       = 1'b0
) (
  input  wire logic               clk_sys_in,
  input  wire logic               nrst_in,
  input  wire logic [4:0]         address_in,
  input  wire logic               read_in,
  input  wire logic               write_in,
  input  wire logic [ADDR_W-1:0]  writedata_in,
  input  wire logic [3:0]         byteenable_in,
  output logic [ADDR_W-1:0]       readdata_out,
  output logic                    waitrequest_out,
  input  wire logic               d_valid_in,
  input  wire logic [ADDR_W-1:0]  d_addr_in,
  input  wire logic               d_write_in,
  input  wire logic               d_user_in,
  input  wire logic               i_valid_in,
  input  wire logic [ADDR_W-1:0]  i_addr_in,
  input  wire logic               i_user_in,
  output logic                    d_fault_out,
  output logic                    i_fault_out,
  output logic [MTYPE_W-1:0]      d_mem_type_out,
  output logic                    d_cacheable_out,
  output logic                    d_bufferable_out,
  output logic                    irq_out
);
  typedef struct packed {
    logic                enable;
    logic [ADDR_W-1:0]   base_sel;
    logic [ADDR_W-1:0]   attr;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] irq_mask;
    logic [ADDR_W-1:0]   fault_addr;
    logic [ADDR_W-1:0]   rdata;
    logic                ack;
    logic                d_fault;
    logic                i_fault;
    logic [MTYPE_W-1:0]  d_mtype;
  } top_state_type;

  top_state_type state_reg;
  top_state_type state_next;

  region_view_if #(.NUM(DATA_REGIONS))  d_view ();
  region_view_if #(.NUM(INSTR_REGIONS)) i_view ();

  logic [ADDR_W-1:0]   rd_value;
  logic [ADDR_W-1:0]   be_bits;
  logic [ADDR_W-1:0]   wmerged;
  logic                wr_take;
  logic                attr_take;
  logic                sel_data;
  logic [IDX_W-1:0]    sel_idx;
  logic                store_req;
  logic                load_req;
  logic [FIELD_W-1:0]  sel_base;
  logic [FIELD_W-1:0]  sel_ext;
  logic [ACCESS_W-1:0] sel_access;
  logic [MTYPE_W-1:0]  sel_mtype;
  logic                d_hit;
  logic                d_allowed;
  logic [MTYPE_W-1:0]  d_mtype_now;
  logic                i_hit;
  logic                i_allowed;
  logic                d_bad;
  logic                i_bad;
  logic                status_d_set;

  function automatic logic [ADDR_W-1:0] expand_be(input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      expand_be[b*8 +: 8] = {8{be[b]}};
    end
  endfunction

  assign be_bits   = expand_be(byteenable_in);
  assign wmerged   = (rd_value & ~be_bits) | (writedata_in & be_bits);
  assign wr_take   = write_in && state_reg.ack;
  assign attr_take = wr_take && (address_in == OFS_ATTR);
  assign sel_data  = state_reg.base_sel[BASE_D_BIT];
  assign sel_idx   = state_reg.base_sel[BASE_IDX_LSB +: IDX_W];
  assign store_req = attr_take && wmerged[ATTR_WR_BIT];
  assign load_req  = attr_take && wmerged[ATTR_RD_BIT];

  // Register read image; trigger bits and reserved bits read as zero
  always_comb begin
    case (address_in)
      OFS_CTRL:       rd_value = {{(ADDR_W-1){1'b0}}, state_reg.enable};
      OFS_BASE:       rd_value = state_reg.base_sel;
      OFS_ATTR:       rd_value = state_reg.attr;
      OFS_STATUS:     rd_value = {{(ADDR_W-STATUS_W){1'b0}}, state_reg.status};
      OFS_IRQ_MASK:   rd_value = {{(ADDR_W-STATUS_W){1'b0}}, state_reg.irq_mask};
      OFS_FAULT_ADDR: rd_value = state_reg.fault_addr;
      default:        rd_value = '0;
    endcase
  end

  // Region picked by the base register for read-back
  always_comb begin
    sel_base   = '0;
    sel_ext    = '0;
    sel_access = '0;
    sel_mtype  = '0;
    if (sel_data && (32'(sel_idx) < DATA_REGIONS)) begin
      sel_base   = d_view.base[sel_idx];
      sel_ext    = d_view.extent[sel_idx];
      sel_access = d_view.access[sel_idx];
      sel_mtype  = d_view.mtype[sel_idx];
    end else if (!sel_data && (32'(sel_idx) < INSTR_REGIONS)) begin
      sel_base   = i_view.base[sel_idx];
      sel_ext    = i_view.extent[sel_idx];
      sel_access = i_view.access[sel_idx];
      sel_mtype  = i_view.mtype[sel_idx];
    end
  end

  region_store #(.NUM(DATA_REGIONS), .GRAN_LOG2(DATA_GRAN_LOG2)) u_d_store (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .store_in   (store_req && sel_data),
    .index_in   (sel_idx),
    .base_in    (state_reg.base_sel[ADDR_W-1:FIELD_LSB]),
    .extent_in  (wmerged[ADDR_W-1:FIELD_LSB]),
    .access_in  (wmerged[ATTR_ACC_LSB +: ACCESS_W]),
    .mtype_in   (wmerged[ATTR_MTYPE_LSB +: MTYPE_W]),
    .view       (d_view)
  );

  region_store #(.NUM(INSTR_REGIONS), .GRAN_LOG2(INSTR_GRAN_LOG2)) u_i_store (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .store_in   (store_req && !sel_data),
    .index_in   (sel_idx),
    .base_in    (state_reg.base_sel[ADDR_W-1:FIELD_LSB]),
    .extent_in  (wmerged[ADDR_W-1:FIELD_LSB]),
    .access_in  (wmerged[ATTR_ACC_LSB +: ACCESS_W]),
    .mtype_in   (wmerged[ATTR_MTYPE_LSB +: MTYPE_W]),
    .view       (i_view)
  );

  region_match #(.NUM(DATA_REGIONS), .USE_LIMIT(USE_LIMIT)) u_d_match (
    .addr_in     (d_addr_in),
    .write_in    (d_write_in),
    .user_in     (d_user_in),
    .view        (d_view),
    .hit_out     (d_hit),
    .allowed_out (d_allowed),
    .mtype_out   (d_mtype_now)
  );

  // Fetches are checked as reads
  region_match #(.NUM(INSTR_REGIONS), .USE_LIMIT(USE_LIMIT)) u_i_match (
    .addr_in     (i_addr_in),
    .write_in    (1'b0),
    .user_in     (i_user_in),
    .view        (i_view),
    .hit_out     (i_hit),
    .allowed_out (i_allowed),
    .mtype_out   ()
  );

  assign d_bad = state_reg.enable && d_valid_in && !(d_hit && d_allowed);
  assign i_bad = state_reg.enable && i_valid_in && !(i_hit && i_allowed);

  always_comb begin
    state_next = state_reg;
    state_next.ack = (read_in || write_in) && !state_reg.ack;
    if (read_in && !state_reg.ack) begin
      state_next.rdata = rd_value;
    end
    if (wr_take) begin
      case (address_in)
        OFS_CTRL:     state_next.enable   = wmerged[CTRL_EN_BIT];
        OFS_BASE:     state_next.base_sel = wmerged & BASE_RW_MASK;
        OFS_ATTR:     state_next.attr     = wmerged & ATTR_RW_MASK;
        OFS_IRQ_MASK: state_next.irq_mask = wmerged[STATUS_W-1:0];
        default:      state_next.enable   = state_reg.enable;
      endcase
    end
    if (load_req) begin
      state_next.base_sel = {sel_base, state_reg.base_sel[FIELD_LSB-1:0]};
      state_next.attr     = {sel_ext, 1'b0, sel_mtype, sel_access, 2'b00};
    end
    // Clear by writing one, but a fault in the same cycle still lands
    if (wr_take && (address_in == OFS_STATUS)) begin
      state_next.status = state_reg.status & ~(writedata_in[STATUS_W-1:0] & be_bits[STATUS_W-1:0]);
    end
    state_next.status[ST_DATA_BIT]  = state_next.status[ST_DATA_BIT] | d_bad;
    state_next.status[ST_INSTR_BIT] = state_next.status[ST_INSTR_BIT] | i_bad;
    state_next.d_fault = d_bad;
    state_next.i_fault = i_bad;
    if (d_valid_in) begin
      state_next.d_mtype = d_mtype_now;
    end
    if (d_bad) begin
      state_next.fault_addr = d_addr_in;
    end else if (i_bad) begin
      state_next.fault_addr = i_addr_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readdata_out     = state_reg.rdata;
  assign waitrequest_out  = (read_in || write_in) && !state_reg.ack;
  assign d_fault_out      = state_reg.d_fault;
  assign i_fault_out      = state_reg.i_fault;
  assign d_mem_type_out   = state_reg.d_mtype;
  assign d_cacheable_out  = mem_cacheable(state_reg.d_mtype);
  assign d_bufferable_out = mem_bufferable(state_reg.d_mtype);
  assign irq_out          = |(state_reg.status & state_reg.irq_mask);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_load_taken;
    load_req;
  endsequence

  sequence s_data_store;
    store_req && sel_data;
  endsequence

  a_data_miss_fault: assert property (state_reg.enable && d_valid_in && !d_hit |=> d_fault_out && status_d_set)
    else $error("Data access outside every region did not fault");
  a_disabled_silent: assert property (!state_reg.enable |=> !d_fault_out && !i_fault_out)
    else $error("Fault raised while checking was disabled");
  a_instr_deny_fault: assert property (state_reg.enable && i_valid_in && i_hit && !i_allowed |=> i_fault_out)
    else $error("Denied fetch did not fault");
  a_low_index_wins: assert property (u_d_match.hit_vec[0] |-> d_mtype_now == d_view.mtype[0])
    else $error("Region zero did not win the match");
  a_load_fills_attr: assert property (s_load_taken |=> state_reg.attr[ATTR_ACC_LSB +: ACCESS_W] == $past(sel_access))
    else $error("Attribute load did not copy the region");
  a_data_keeps_instr: assert property (s_data_store |=> $stable(i_view.extent) && $stable(i_view.base))
    else $error("Data region store touched the instruction table");
  a_mem_type_decode: assert property (d_valid_in ##1 (d_mem_type_out == MEM_DEVICE) |-> !d_cacheable_out && d_bufferable_out)
    else $error("Device memory type decoded wrongly");
  a_bus_one_wait: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("Bus answer took more than one wait cycle");
  a_fault_irq: assert property (d_bad && state_reg.irq_mask[ST_DATA_BIT] |=> irq_out)
    else $error("Unmasked data fault did not raise the interrupt");

  assign status_d_set = state_reg.status[ST_DATA_BIT];

  sequence s_data_ok;
    d_valid_in && d_hit && d_allowed;
  endsequence

  sequence s_fetch_ok;
    i_valid_in && i_hit && i_allowed;
  endsequence

  sequence s_instr_store;
    store_req && !sel_data;
  endsequence

  sequence s_status_clear;
    wr_take && (address_in == OFS_STATUS) && writedata_in[ST_DATA_BIT] && byteenable_in[0];
  endsequence

  a_data_legal_quiet: assert property (s_data_ok |=> !d_fault_out)
    else $error("Legal data access faulted");
  a_fetch_legal_quiet: assert property (s_fetch_ok |=> !i_fault_out)
    else $error("Legal fetch faulted");
  a_instr_miss_fault: assert property (state_reg.enable && i_valid_in && !i_hit |=> i_fault_out)
    else $error("Stray fetch did not fault");

  a_fault_addr_kept: assert property (d_bad |=> state_reg.fault_addr == $past(d_addr_in))
    else $error("Fault address not kept");
  a_instr_keeps_data: assert property (s_instr_store |=> $stable(d_view.base) && $stable(d_view.extent))
    else $error("Instruction store changed data regions");

  // Memory type stands until the next data access
  a_type_holds: assert property (!d_valid_in |=> $stable(d_mem_type_out))
    else $error("Memory type moved without access");

  // A fault in the clearing cycle wins over the clear
  a_status_clear: assert property (s_status_clear ##0 !d_bad |=> !status_d_set)
    else $error("Data fault status not cleared");
  a_status_sticky: assert property (status_d_set && !(wr_take && address_in == OFS_STATUS) |=> status_d_set)
    else $error("Data fault status lost");
endmodule

// ==== rtl/mpu_pkg.sv ====
/*
  Constants, types and small decoders shared by the protection checker,
  its region store and its region matcher.
  Assumes a 32-bit byte address space and regions placed on 256-byte steps.
*/
// Overview of operation
// - Enabled unit checks all fetches and data accesses
// - Build option picks mask or limit extent
// - Data region count 2 to 32, default 8
// - Instruction region count 2 to 32, default 8
// - Data granularity 256 B to 1 MB, default 4 KB
// - Instruction granularity 256 B to 1 MB, default 4 KB
// - Region sizes are multiples of the granularity
// - Data and instruction granularities are independent
// - Type bit one selects data, zero instruction
// - Lower region index has higher priority
// - Memory type: peripheral, normal, device, reserved
// - Attribute write triggers region load or store
package mpu_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned PAGE_LSB      = 8;
  localparam int unsigned FIELD_W       = ADDR_W - PAGE_LSB;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned ACCESS_W      = 3;
  localparam int unsigned MTYPE_W       = 2;
  localparam int unsigned DEF_REGIONS   = 8;
  localparam int unsigned DEF_GRAN_LOG2 = 12;
  localparam int unsigned STATUS_W      = 2;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL       = 5'h00;
  localparam logic [4:0] OFS_BASE       = 5'h04;
  localparam logic [4:0] OFS_ATTR       = 5'h08;
  localparam logic [4:0] OFS_STATUS     = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h10;
  localparam logic [4:0] OFS_FAULT_ADDR = 5'h14;

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned BASE_D_BIT     = 0;
  localparam int unsigned BASE_IDX_LSB   = 1;
  localparam int unsigned FIELD_LSB      = PAGE_LSB;
  localparam int unsigned ATTR_WR_BIT    = 0;
  localparam int unsigned ATTR_RD_BIT    = 1;
  localparam int unsigned ATTR_ACC_LSB   = 2;
  localparam int unsigned ATTR_MTYPE_LSB = 5;
  localparam int unsigned ST_DATA_BIT    = 0;
  localparam int unsigned ST_INSTR_BIT   = 1;

  localparam logic [ADDR_W-1:0] BASE_RW_MASK = 32'hFFFFFF3F;
  localparam logic [ADDR_W-1:0] ATTR_RW_MASK = 32'hFFFFFF7C;

  typedef enum logic [MTYPE_W-1:0] {
    MEM_PERIPHERAL = 2'h0,
    MEM_NORMAL     = 2'h1,
    MEM_DEVICE     = 2'h2,
    MEM_RESERVED   = 2'h3
  } mem_kind_type;

  typedef enum logic [ACCESS_W-1:0] {
    ACC_NONE       = 3'h0,
    ACC_SUP_RW     = 3'h1,
    ACC_SUP_RW_URO = 3'h2,
    ACC_ALL_RW     = 3'h3,
    ACC_SUP_RO     = 3'h4,
    ACC_ALL_RO     = 3'h5
  } access_kind_type;

  function automatic logic access_allows(input logic [ACCESS_W-1:0] acc, input logic wr, input logic user);
    case (acc)
      ACC_SUP_RW:     access_allows = !user;
      ACC_SUP_RW_URO: access_allows = !user || !wr;
      ACC_ALL_RW:     access_allows = 1'b1;
      ACC_SUP_RO:     access_allows = !user && !wr;
      ACC_ALL_RO:     access_allows = !wr;
      default:        access_allows = 1'b0;
    endcase
  endfunction

  function automatic logic mem_cacheable(input logic [MTYPE_W-1:0] mt);
    mem_cacheable = (mt == MEM_NORMAL);
  endfunction

  function automatic logic mem_bufferable(input logic [MTYPE_W-1:0] mt);
    mem_bufferable = (mt == MEM_NORMAL) || (mt == MEM_DEVICE);
  endfunction
endpackage

// ==== rtl/region_match.sv ====
/*
  Combinational priority match of one address against a region table.
  Assumes regions with a zero extent field are disabled.
*/
`timescale 1ns/1ps
module region_match
  import mpu_pkg::*;
#(
  parameter int unsigned NUM       = DEF_REGIONS,
  parameter bit          USE_LIMIT = 1'b0
) (
  input  wire logic [ADDR_W-1:0]  addr_in,
  input  wire logic               write_in,
  input  wire logic               user_in,
  region_view_if.match_mp         view,
  output logic                    hit_out,
  output logic                    allowed_out,
  output logic [MTYPE_W-1:0]      mtype_out
);
  logic [FIELD_W-1:0] page;
  logic [NUM-1:0]     hit_vec;

  assign page = addr_in[ADDR_W-1:PAGE_LSB];

  for (genvar g = 0; g < NUM; g++) begin : g_hit
    // Limit is exclusive, mask keeps only the bits above the region size
    assign hit_vec[g] = (view.extent[g] != '0) &&
                        (USE_LIMIT ? ((page >= view.base[g]) && (page < view.extent[g]))
                                   : ((page & view.extent[g]) == (view.base[g] & view.extent[g])));
  end

  always_comb begin
    hit_out     = 1'b0;
    allowed_out = 1'b0;
    mtype_out   = MEM_PERIPHERAL;
    // Walk downward so the lowest matching index is the one that sticks
    for (int i = int'(NUM) - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_out     = 1'b1;
        allowed_out = access_allows(view.access[i], write_in, user_in);
        mtype_out   = view.mtype[i];
      end
    end
  end
endmodule

// ==== rtl/region_store.sv ====
/*
  Flip-flop table of protection regions for one access type.
  Assumes a one-cycle store strobe from the register block.
*/
`timescale 1ns/1ps
module region_store
  import mpu_pkg::*;
#(
  parameter int unsigned NUM       = DEF_REGIONS,
  parameter int unsigned GRAN_LOG2 = DEF_GRAN_LOG2
) (
  input  wire logic                clk_sys_in,
  input  wire logic                nrst_in,
  input  wire logic                store_in,
  input  wire logic [IDX_W-1:0]    index_in,
  input  wire logic [FIELD_W-1:0]  base_in,
  input  wire logic [FIELD_W-1:0]  extent_in,
  input  wire logic [ACCESS_W-1:0] access_in,
  input  wire logic [MTYPE_W-1:0]  mtype_in,
  region_view_if.store_mp          view
);
  localparam logic [FIELD_W-1:0] LOW_ONES = FIELD_W'((1 << (GRAN_LOG2 - PAGE_LSB)) - 1);

  typedef struct packed {
    logic [NUM-1:0][FIELD_W-1:0]  base;
    logic [NUM-1:0][FIELD_W-1:0]  extent;
    logic [NUM-1:0][ACCESS_W-1:0] access;
    logic [NUM-1:0][MTYPE_W-1:0]  mtype;
  } store_state_type;

  store_state_type state_reg;
  store_state_type state_next;
  logic            low_bits_set;

  always_comb begin
    state_next = state_reg;
    if (store_in && (32'(index_in) < NUM)) begin
      // Bits below the granularity cannot be stored, so no region is finer
      state_next.base[index_in]   = base_in & ~LOW_ONES;
      state_next.extent[index_in] = extent_in & ~LOW_ONES;
      state_next.access[index_in] = access_in;
      state_next.mtype[index_in]  = mtype_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign view.base   = state_reg.base;
  assign view.extent = state_reg.extent;
  assign view.access = state_reg.access;
  assign view.mtype  = state_reg.mtype;

  always_comb begin
    low_bits_set = 1'b0;
    for (int i = 0; i < NUM; i++) begin
      low_bits_set = low_bits_set | (|((state_reg.base[i] | state_reg.extent[i]) & LOW_ONES));
    end
  end

  a_grain_aligned: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) !low_bits_set)
    else $error("Stored region is not aligned to the granularity");
endmodule

// ==== rtl/region_view_if.sv ====
/*
  Region table contents as seen by the matcher.
  Assumes one store drives it and matchers and the top only read it.
*/
`timescale 1ns/1ps
interface region_view_if
  import mpu_pkg::*;
#(parameter int unsigned NUM = DEF_REGIONS);
  logic [NUM-1:0][FIELD_W-1:0]  base;
  logic [NUM-1:0][FIELD_W-1:0]  extent;
  logic [NUM-1:0][ACCESS_W-1:0] access;
  logic [NUM-1:0][MTYPE_W-1:0]  mtype;
  modport store_mp (output base, extent, access, mtype);
  modport match_mp (input base, extent, access, mtype);
endinterface

// ==== verif/core_model.sv ====
/*
  Behavioural processor core: Avalon-MM register master plus data and fetch access issuer.
  Assumes the checker's bus and access ports share clk_sys_in with this model.
*/
`timescale 1ns/1ps
module core_model
  import mpu_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic [ADDR_W-1:0] readdata_in,
  input  wire logic              waitrequest_in,
  output logic [4:0]             address_out,
  output logic                   read_out,
  output logic                   write_out,
  output logic [ADDR_W-1:0]      writedata_out,
  output logic [3:0]             byteenable_out,
  output logic                   d_valid_out,
  output logic [ADDR_W-1:0]      d_addr_out,
  output logic                   d_write_out,
  output logic                   d_user_out,
  output logic                   i_valid_out,
  output logic [ADDR_W-1:0]      i_addr_out,
  output logic                   i_user_out
);
  initial begin
    address_out    = 5'h1F;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = 32'h5A5A5A5A;
    byteenable_out = 4'hF;
    d_valid_out    = 1'b0;
    d_addr_out     = 32'hA5A5A5A5;
    d_write_out    = 1'b0;
    d_user_out     = 1'b0;
    i_valid_out    = 1'b0;
    i_addr_out     = 32'hA5A5A5A5;
    i_user_out     = 1'b0;
  end

  // Released write data and access addresses show the inverse so stale values cannot pass for live ones
  task automatic bus_wr(input logic [4:0] a, input logic [ADDR_W-1:0] d);
    @(posedge clk_sys_in);
    address_out   <= a;
    writedata_out <= d;
    write_out     <= 1'b1;
    do @(posedge clk_sys_in); while (waitrequest_in !== 1'b0);
    write_out     <= 1'b0;
    writedata_out <= ~d;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [ADDR_W-1:0] d);
    @(posedge clk_sys_in);
    address_out <= a;
    read_out    <= 1'b1;
    do @(posedge clk_sys_in); while (waitrequest_in !== 1'b0);
    d = readdata_in;
    read_out    <= 1'b0;
  endtask

  task automatic access(input logic fetch, input logic [ADDR_W-1:0] a, input logic w, input logic u);
    @(posedge clk_sys_in);
    if (fetch) begin
      i_valid_out <= 1'b1;
      i_addr_out  <= a;
      i_user_out  <= u;
    end else begin
      d_valid_out <= 1'b1;
      d_addr_out  <= a;
      d_write_out <= w;
      d_user_out  <= u;
    end
    @(posedge clk_sys_in);
    d_valid_out <= 1'b0;
    i_valid_out <= 1'b0;
    d_addr_out  <= ~a;
    i_addr_out  <= ~a;
  endtask
endmodule

// ==== verif/memory_protection_region_checker_tb_top.sv ====
/*
  Self-checking bench for mpu_checker: region programming, priority match, faults, interrupt.
  Assumes core_model as the only bus master and access source.
*/
`timescale 1ns/1ps
module memory_protection_region_checker_tb_top
  import mpu_pkg::*;
;
  typedef struct packed {
    logic        fetch;
    logic [31:0] addr;
    logic        wr;
    logic        user;
    logic        fault;
    logic [1:0]  mt;
  } row_type;

  logic              clk = 1'b0;
  logic              nrst;
  logic [4:0]        address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic              d_valid, d_write, d_user, i_valid, i_user;
  logic [31:0]       d_addr, i_addr;
  logic              d_fault, i_fault, d_cache, d_buf, irq, lim_fault;
  logic [1:0]        d_mt;
  logic [31:0]       rd;
  int                err_total = 0;
  int                samples_checked = 0;
  row_type           rows [0:10] = '{
    '{1'b0, 32'h00001080, 1'b0, 1'b1, 1'b0, 2'h2}, '{1'b0, 32'h00001080, 1'b1, 1'b1, 1'b1, 2'h2},
    '{1'b0, 32'h00001180, 1'b1, 1'b1, 1'b0, 2'h1}, '{1'b0, 32'h00020010, 1'b1, 1'b0, 1'b0, 2'h0},
    '{1'b0, 32'h00020010, 1'b0, 1'b1, 1'b1, 2'h0}, '{1'b0, 32'h00040000, 1'b0, 1'b1, 1'b0, 2'h3},
    '{1'b0, 32'h00030000, 1'b0, 1'b0, 1'b1, 2'h0}, '{1'b1, 32'h00000100, 1'b0, 1'b0, 1'b0, 2'h0},
    '{1'b1, 32'h00000100, 1'b0, 1'b1, 1'b1, 2'h0}, '{1'b1, 32'h00001F00, 1'b0, 1'b1, 1'b0, 2'h0},
    '{1'b1, 32'h00005000, 1'b0, 1'b0, 1'b1, 2'h0}};

  always #10 clk = ~clk;

  // Small counts and unequal granularities make boundary and independence visible
  mpu_checker #(.DATA_REGIONS(4), .INSTR_REGIONS(2), .DATA_GRAN_LOG2(8), .INSTR_GRAN_LOG2(12),
                .USE_LIMIT(1'b0)) dut (
    .clk_sys_in(clk), .nrst_in(nrst), .address_in(address), .read_in(read), .write_in(write),
    .writedata_in(writedata), .byteenable_in(byteenable), .readdata_out(readdata),
    .waitrequest_out(waitrequest), .d_valid_in(d_valid), .d_addr_in(d_addr), .d_write_in(d_write),
    .d_user_in(d_user), .i_valid_in(i_valid), .i_addr_in(i_addr), .i_user_in(i_user),
    .d_fault_out(d_fault), .i_fault_out(i_fault), .d_mem_type_out(d_mt), .d_cacheable_out(d_cache),
    .d_bufferable_out(d_buf), .irq_out(irq));

  mpu_checker #(.DATA_REGIONS(4), .INSTR_REGIONS(2), .DATA_GRAN_LOG2(8), .INSTR_GRAN_LOG2(12),
                .USE_LIMIT(1'b1)) dut_lim (
    .clk_sys_in(clk), .nrst_in(nrst), .address_in(address), .read_in(read), .write_in(write),
    .writedata_in(writedata), .byteenable_in(byteenable), .readdata_out(), .waitrequest_out(),
    .d_valid_in(d_valid), .d_addr_in(d_addr), .d_write_in(d_write), .d_user_in(d_user),
    .i_valid_in(i_valid), .i_addr_in(i_addr), .i_user_in(i_user), .d_fault_out(lim_fault),
    .i_fault_out(), .d_mem_type_out(), .d_cacheable_out(), .d_bufferable_out(), .irq_out());

  core_model core (
    .clk_sys_in(clk), .readdata_in(readdata), .waitrequest_in(waitrequest), .address_out(address),
    .read_out(read), .write_out(write), .writedata_out(writedata), .byteenable_out(byteenable),
    .d_valid_out(d_valid), .d_addr_out(d_addr), .d_write_out(d_write), .d_user_out(d_user),
    .i_valid_out(i_valid), .i_addr_out(i_addr), .i_user_out(i_user));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic set_region(input logic d, input logic [4:0] idx, input logic [23:0] page,
                            input logic [23:0] ext, input logic [2:0] acc, input logic [1:0] mt);
    core.bus_wr(OFS_BASE, {page, 2'b00, idx, d});
    core.bus_wr(OFS_ATTR, {ext, 1'b0, mt, acc, 2'b01});
  endtask

  task automatic try(input row_type r);
    core.access(r.fetch, r.addr, r.wr, r.user);
    @(negedge clk);
    chk({31'h0, r.fetch ? i_fault : d_fault}, {31'h0, r.fault});
    if (!r.fetch) begin
      chk({30'h0, d_mt}, {30'h0, r.mt});
      chk({30'h0, d_cache, d_buf}, {30'h0, r.mt == 2'h1, r.mt == 2'h1 || r.mt == 2'h2});
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // Includes the unmapped offset 0x18, which must read as zero
    for (int a = 0; a <= 24; a += 4) begin
      core.bus_rd(a[4:0], rd);
      chk(rd, 32'h0);
    end
    set_region(1'b1, 5'd0, 24'h000010, 24'hFFFFFF, ACC_ALL_RO, MEM_DEVICE);
    set_region(1'b1, 5'd1, 24'h000000, 24'hFFFF00, ACC_ALL_RW, MEM_NORMAL);
    set_region(1'b1, 5'd2, 24'h000200, 24'hFFFFF0, ACC_SUP_RW, MEM_PERIPHERAL);
    set_region(1'b1, 5'd3, 24'h000400, 24'hFFFFFF, ACC_ALL_RW, MEM_RESERVED);
    set_region(1'b0, 5'd0, 24'h000000, 24'hFFFFF0, ACC_SUP_RO, MEM_NORMAL);
    set_region(1'b0, 5'd1, 24'h000011, 24'hFFFFFF, ACC_ALL_RW, MEM_NORMAL);
    core.bus_wr(OFS_BASE, 32'h00000002);
    core.bus_wr(OFS_ATTR, 32'h00000002);
    core.bus_rd(OFS_BASE, rd);
    chk(rd, 32'h00001002);
    core.bus_rd(OFS_ATTR, rd);
    chk(rd, 32'hFFFFF02C);
    core.bus_wr(OFS_CTRL, 32'h1);
    foreach (rows[i]) try(rows[i]);
    core.access(1'b0, 32'h00001180, 1'b1, 1'b1);
    @(negedge clk);
    chk({30'h0, lim_fault, d_fault}, 32'h2);
    core.bus_rd(OFS_FAULT_ADDR, rd);
    chk(rd, 32'h00005000);
    core.bus_rd(OFS_STATUS, rd);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    core.bus_wr(OFS_IRQ_MASK, 32'h3);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    core.bus_wr(OFS_STATUS, 32'h1);
    core.bus_rd(OFS_STATUS, rd);
    chk({rd[30:0], irq}, 32'h5);
    core.bus_wr(OFS_STATUS, 32'h2);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    core.bus_wr(OFS_CTRL, 32'h0);
    try('{1'b0, 32'h00030000, 1'b0, 1'b0, 1'b0, 2'h0});
    set_region(1'b1, 5'd2, 24'h000200, 24'hFFFFF0, ACC_ALL_RW, MEM_PERIPHERAL);
    core.bus_wr(OFS_CTRL, 32'h1);
    try('{1'b0, 32'h00020010, 1'b1, 1'b1, 1'b0, 2'h0});
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    core.bus_rd(OFS_CTRL, rd);
    chk(rd, 32'h0);
    core.bus_wr(OFS_CTRL, 32'h1);
    // Cleared table leaves every region disabled, so any access misses
    try('{1'b0, 32'h00001080, 1'b0, 1'b1, 1'b1, 2'h0});
    print_verdict();
  end
endmodule
